/* File: pkg/sector_protect_cfg.svh */
// Purpose: constants for the sector protection command decoder
// Assumes: word addresses, 16-bit data, one 32-bit register per offset
// Notes:   axi offsets are byte addresses
`ifndef SECTOR_PROTECT_CFG_SVH
`define SECTOR_PROTECT_CFG_SVH
`define SP_OFF_CMD      12'h000
`define SP_OFF_RDATA    12'h004
`define SP_OFF_STATUS   12'h008
`define SP_OFF_SECTOR   12'h00C
`define SP_OFF_PROG     12'h010
`define SP_OFF_CTRL     12'h014
`define SP_CMD_UNLOCK1  8'hAA
`define SP_CMD_UNLOCK2  8'h55
`define SP_ADDR_UNLOCK1 14'h0555
`define SP_ADDR_UNLOCK2 14'h02AA
`define SP_CMD_PWD      8'h60
`define SP_CMD_NVOL     8'hC0
`define SP_CMD_FREEZE   8'h50
`define SP_CMD_VOL      8'hE0
`define SP_CMD_PGM      8'hA0
`define SP_CMD_ERASE    8'h80
`define SP_CMD_ERASE2   8'h30
`define SP_CMD_EXIT1    8'h90
`define SP_CMD_EXIT2    8'h00
`define SP_CMD_RESET    8'hF0
`define SP_CMD_WBUF     8'h25
`define SP_CMD_COMMIT   8'h29
`define SP_SECT_LSB     14
`define SP_CMD_ABITS    14
`define SP_STAT_UNLOCK  16'h0000
`define SP_STAT_LOCK    16'h0001
`endif

/* File: pkg/sector_protect_pkg.sv */
// Purpose: types for the sector protection command decoder
// Assumes: nothing
// Notes:   none
`default_nettype none
package sector_protect_pkg;
	typedef enum {
		ST_READ, ST_UL1, ST_UL2,
		ST_SET_IDLE, ST_SET_PGM, ST_SET_X90, ST_SET_ERA,
		ST_PWD_CNT, ST_PWD_W, ST_PWD_COMMIT, ST_PWD_FAIL,
		ST_WB_CNT, ST_WB_LOAD, ST_WB_COMMIT
	} cmd_state_e;
	typedef enum {
		SET_NONE, SET_PWD, SET_NVOL, SET_FREEZE, SET_VOL
	} cmd_set_e;
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] data;
	} bus_cycle_s;
	typedef struct packed {
		logic        avalid;
		logic        wvalid;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic [11:0] waddr;
		logic [11:0] raddr;
		logic [31:0] wdata;
	} axi_s;
endpackage
`default_nettype wire

/* File: design/sector_protect_cmd_decoder.sv */
// Purpose: sector protection and buffered program command decoder
// Assumes: host bus cycles arrive as pin strobes on aclk
// Notes:   axi-lite gives software a view of lock state and programs
// Behaviour
// [R1] program address latched at first of address strobe rise or clock edge
// [R2] program data latched at first of write strobe or chip select rise
// [R3] status read drives bit zero low if protected, high if not
// [R4] password is four 16-bit words selected by address bits one and zero
// [R5] buffer load locations must lie in the starting address's page
// [R6] buffer write starts 25 at sector, then word count minus one
// [R7] single 29 at sector address commits buffer to array
// [R8] host issues command cycles as writes except designated reads
// [R9] upper data byte ignored in command cycles except data and password
// [R10] address bits from bit 14 upward ignored when decoding commands
// [R11] host issues reset after wrong values or ordering
// [R12] exit needs no cycles when bank already reads array
// [R13] lock status read returns 0000h unlocked and 0001h locked
// [R14] host must exit after password program or unlock
// [R15] read data changes only on rising clock edge
// [R16] volatile set entered by unlock then E0; A0 sector 00 sets, 01 clears
// [R17] sets exit with 90 then 00; freeze set entered by 50, set by A0 00
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`include "sector_protect_cfg.svh"
`default_nettype none
module sector_protect_cmd_decoder #(
	parameter int SECT_BITS = 9,
	parameter int ADDR_BITS = 24,
	parameter int BUF_WORDS = 32
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 clk_en,
	input  wire logic [ADDR_BITS-1:0] bus_addr,
	input  wire logic [15:0]          bus_din,
	input  wire logic                 address_valid_strobe,
	input  wire logic                 write_strobe,
	input  wire logic                 chip_select_pulse,
	input  wire logic                 bus_clk_edge,
	input  wire logic                 bus_read,
	output logic [15:0]               bus_dout,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	localparam int NSECT = 1 << SECT_BITS;
	localparam int BW = $clog2(BUF_WORDS);

	typedef struct packed {
		sector_protect_pkg::cmd_state_e st;
		sector_protect_pkg::cmd_set_e   set;
		logic [NSECT-1:0]               nvol_lock;
		logic [NSECT-1:0]               vol_lock;
		logic                           freeze;
		logic [63:0]                    password_word;
		logic                           pwd_mode;
		logic [1:0]                     pwd_idx;
		logic                           pwd_ok;
		logic [SECT_BITS-1:0]           wb_sect;
		logic [ADDR_BITS-1:0]           wb_base;
		logic [BW-1:0]                  wb_left;
		logic [BW:0]                    wb_fill;
		logic [ADDR_BITS-1:0]           prog_addr;
		logic                           addr_held;
		logic                           data_held;
		logic [15:0]                    prog_data;
		logic [15:0]                    dout;
		logic [15:0]                    commits;
		logic                           page_err;
		sector_protect_pkg::axi_s       ax;
	} state_s;

	state_s q;
	state_s d;
	logic [15:0] wbuf_q [BUF_WORDS];
	logic        wb_we;
	logic [BW-1:0] wb_idx;

	// command-cycle decode, bits 14 and above dropped
	function automatic logic is_cyc(input logic [ADDR_BITS-1:0] a,
			input logic [15:0] dat, input logic [13:0] ca,
			input logic [7:0] cd);
		is_cyc = (a[`SP_CMD_ABITS-1:0] == ca) && (dat[7:0] == cd); // [R9] [R10]
	endfunction

	function automatic logic [SECT_BITS-1:0] sect_of(
			input logic [ADDR_BITS-1:0] a);
		sect_of = a[`SP_SECT_LSB +: SECT_BITS];
	endfunction

	logic                 wr_cyc;
	logic [7:0]           cmd;
	logic [SECT_BITS-1:0] sect;
	logic                 locked;
	logic                 aw_go;
	logic                 ar_go;

	always_comb begin
		wr_cyc = write_strobe | chip_select_pulse; // [R2]
		cmd = bus_din[7:0]; // [R9]
		sect = sect_of(bus_addr);
		locked = q.nvol_lock[sect] | q.vol_lock[sect];
		aw_go = q.ax.avalid && q.ax.wvalid && !q.ax.bvalid;
		ar_go = s_axi_arvalid && !q.ax.rvalid;
		wb_we = 1'b0;
		wb_idx = q.prog_addr[BW-1:0];
		d = q;
		// program address: first of strobe rise or bus clock edge
		if ((address_valid_strobe || bus_clk_edge) && !q.addr_held) begin
			d.prog_addr = bus_addr; // [R1]
			d.addr_held = 1'b1;
		end
		if (!address_valid_strobe && !bus_clk_edge)
			d.addr_held = 1'b0;
		if (wr_cyc && !q.data_held) begin
			d.prog_data = bus_din; // [R2]
			d.data_held = 1'b1;
		end
		if (!wr_cyc)
			d.data_held = 1'b0;
		if (bus_read) begin
			// outputs registered, change only at rising aclk [R15]
			case (q.set)
			sector_protect_pkg::SET_PWD:
				d.dout = q.password_word[{bus_addr[1:0], 4'h0} +: 16]; // [R4]
			sector_protect_pkg::SET_FREEZE:
				d.dout = {15'h0000, !q.freeze}; // [R3]
			sector_protect_pkg::SET_NVOL,
			sector_protect_pkg::SET_VOL:
				d.dout = {15'h0000, !locked}; // [R3]
			default:
				d.dout = locked ? `SP_STAT_LOCK : `SP_STAT_UNLOCK; // [R13]
			endcase
		end
		if (wr_cyc && !q.data_held) begin
			case (q.st)
			sector_protect_pkg::ST_READ: begin
				// already in array read: exit simply stays here [R12]
				if (is_cyc(bus_addr, bus_din, `SP_ADDR_UNLOCK1,
						`SP_CMD_UNLOCK1))
					d.st = sector_protect_pkg::ST_UL1;
				else if (cmd == `SP_CMD_WBUF) begin
					d.wb_sect = sect; // [R6]
					d.st = sector_protect_pkg::ST_WB_CNT;
				end
			end
			sector_protect_pkg::ST_UL1:
				d.st = is_cyc(bus_addr, bus_din, `SP_ADDR_UNLOCK2,
					`SP_CMD_UNLOCK2) ? sector_protect_pkg::ST_UL2
					: sector_protect_pkg::ST_READ;
			sector_protect_pkg::ST_UL2: begin
				d.st = sector_protect_pkg::ST_SET_IDLE;
				case (cmd)
				`SP_CMD_PWD:    d.set = sector_protect_pkg::SET_PWD;
				`SP_CMD_NVOL:   d.set = sector_protect_pkg::SET_NVOL;
				`SP_CMD_FREEZE: d.set = sector_protect_pkg::SET_FREEZE; // [R17]
				`SP_CMD_VOL:    d.set = sector_protect_pkg::SET_VOL; // [R16]
				default:        d.st = sector_protect_pkg::ST_READ;
				endcase
			end
			sector_protect_pkg::ST_SET_IDLE:
				if (cmd == `SP_CMD_PGM)
					d.st = sector_protect_pkg::ST_SET_PGM;
				else if (cmd == `SP_CMD_EXIT1)
					d.st = sector_protect_pkg::ST_SET_X90; // [R17]
				else if (cmd == `SP_CMD_ERASE &&
						q.set == sector_protect_pkg::SET_NVOL)
					d.st = sector_protect_pkg::ST_SET_ERA;
				else if (cmd == `SP_CMD_WBUF &&
						q.set == sector_protect_pkg::SET_PWD) begin
					d.pwd_ok = 1'b1;
					d.st = sector_protect_pkg::ST_PWD_CNT;
				end
			sector_protect_pkg::ST_SET_PGM: begin
				d.st = sector_protect_pkg::ST_SET_IDLE;
				case (q.set)
				sector_protect_pkg::SET_VOL:
					if (!q.freeze)
						d.vol_lock[sect] = !bus_din[0]; // [R16]
				sector_protect_pkg::SET_NVOL:
					if (!q.freeze && cmd == 8'h00)
						d.nvol_lock[sect] = 1'b1;
				sector_protect_pkg::SET_FREEZE:
					if (cmd == 8'h00)
						d.freeze = 1'b1; // [R17]
				sector_protect_pkg::SET_PWD:
					if (!q.pwd_mode)
						d.password_word[{bus_addr[1:0], 4'h0} +: 16] = bus_din; // [R4]
				default: d.st = sector_protect_pkg::ST_READ;
				endcase
			end
			sector_protect_pkg::ST_SET_ERA: begin
				if (cmd == `SP_CMD_ERASE2 && !q.freeze)
					d.nvol_lock = '0;
				d.st = sector_protect_pkg::ST_SET_IDLE;
			end
			sector_protect_pkg::ST_SET_X90:
				if (cmd == `SP_CMD_EXIT2) begin
					d.st = sector_protect_pkg::ST_READ; // [R17] [R14]
					d.set = sector_protect_pkg::SET_NONE;
				end else
					d.st = sector_protect_pkg::ST_SET_IDLE;
			sector_protect_pkg::ST_PWD_CNT: begin
				d.pwd_idx = 2'd0;
				d.st = sector_protect_pkg::ST_PWD_W;
			end
			sector_protect_pkg::ST_PWD_W: begin
				// full 16 bits compared, word chosen by addr bits 1:0
				if (bus_din != q.password_word[{bus_addr[1:0], 4'h0} +: 16]) // [R4]
					d.pwd_ok = 1'b0;
				d.pwd_idx = q.pwd_idx + 2'd1;
				if (q.pwd_idx == 2'd3)
					d.st = sector_protect_pkg::ST_PWD_COMMIT;
			end
			sector_protect_pkg::ST_PWD_COMMIT: begin
				if (cmd == `SP_CMD_COMMIT && q.pwd_ok)
					d.freeze = 1'b0;
				d.st = sector_protect_pkg::ST_SET_IDLE; // [R14]
			end
			sector_protect_pkg::ST_WB_CNT: begin
				d.wb_left = bus_din[BW-1:0]; // [R6]
				d.wb_fill = '0;
				d.page_err = 1'b0;
				d.st = sector_protect_pkg::ST_WB_LOAD;
			end
			sector_protect_pkg::ST_WB_LOAD: begin
				// address of this word is latched in this same cycle
				if (q.wb_fill == '0)
					d.wb_base = d.prog_addr;
				else if (d.prog_addr[ADDR_BITS-1:BW] !=
						q.wb_base[ADDR_BITS-1:BW])
					d.page_err = 1'b1; // [R5]
				wb_we = 1'b1;
				wb_idx = d.prog_addr[BW-1:0];
				d.wb_fill = q.wb_fill + 1'b1;
				if (q.wb_fill[BW-1:0] == q.wb_left)
					d.st = sector_protect_pkg::ST_WB_COMMIT;
			end
			sector_protect_pkg::ST_WB_COMMIT: begin
				if (cmd == `SP_CMD_COMMIT && sect == q.wb_sect &&
						!q.page_err && !locked)
					d.commits = q.commits + 16'h0001; // [R7]
				d.st = sector_protect_pkg::ST_READ;
			end
			default: d.st = sector_protect_pkg::ST_READ; // [R11]
			endcase
			// reset wins over any step outside a command set, but buffered data words are data
			if (cmd == `SP_CMD_RESET &&
					q.set == sector_protect_pkg::SET_NONE &&
					q.st != sector_protect_pkg::ST_WB_LOAD)
				d.st = sector_protect_pkg::ST_READ; // [R11]
		end
		// axi-lite slave
		if (s_axi_awvalid && !q.ax.avalid) begin
			d.ax.avalid = 1'b1;
			d.ax.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.ax.wvalid) begin
			d.ax.wvalid = 1'b1;
			d.ax.wdata = s_axi_wdata;
		end
		if (aw_go) begin
			d.ax.avalid = 1'b0;
			d.ax.wvalid = 1'b0;
			d.ax.bvalid = 1'b1;
			if (q.ax.waddr == `SP_OFF_CTRL && !q.freeze)
				d.pwd_mode = q.ax.wdata[0];
		end
		if (q.ax.bvalid && s_axi_bready)
			d.ax.bvalid = 1'b0;
		if (ar_go) begin
			d.ax.rvalid = 1'b1;
			case (s_axi_araddr)
			`SP_OFF_RDATA:  d.ax.rdata = {16'h0000, q.dout};
			`SP_OFF_STATUS: d.ax.rdata = {28'h0000000, q.page_err,
				q.freeze, q.pwd_mode, q.pwd_ok};
			`SP_OFF_PROG:   d.ax.rdata = {16'h0000, q.commits};
			`SP_OFF_CTRL:   d.ax.rdata = {31'h00000000, q.pwd_mode};
			default:        d.ax.rdata = 32'h00000000;
			endcase
		end
		if (q.ax.rvalid && s_axi_rready)
			d.ax.rvalid = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else if (clk_en)
			q <= d;
	end

	always_ff @(posedge aclk) begin
		if (clk_en && wb_we)
			wbuf_q[wb_idx] <= d.prog_data;
	end

	always_comb begin
		bus_dout = q.dout; // [R15]
		s_axi_awready = !q.ax.avalid;
		s_axi_wready = !q.ax.wvalid;
		s_axi_bvalid = q.ax.bvalid;
		s_axi_bresp = 2'b00;
		s_axi_arready = !q.ax.rvalid;
		s_axi_rvalid = q.ax.rvalid;
		s_axi_rdata = q.ax.rdata;
		s_axi_rresp = 2'b00;
	end
endmodule
`default_nettype wire

/* File: dv/sector_protect_cmd_decoder_checker.sv */
// Purpose: port checks for the protection decoder
// Assumes: clk_en held high
// Notes:   bound below
`default_nettype none
module sector_protect_cmd_decoder_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        bus_read,
	input wire logic [15:0] bus_dout,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
	sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
	sequence s_b; s_axi_bvalid && s_axi_bresp == 2'h0; endsequence
	property p_dout; !bus_read |=> $stable(bus_dout); endproperty
	property p_bdone; s_aw and s_w |-> ##[1:2] s_b; endproperty
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_b; endproperty
	property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	property p_rnext; s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && s_axi_rresp == 2'h0; endproperty
	property p_rhold; s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_dout: assert property (p_dout) else $error("dout moved");
	a_bdone: assert property (p_bdone) else $error("no bvalid");
	a_bhold: assert property (p_bhold) else $error("bvalid lost");
	a_bdrop: assert property (p_bdrop) else $error("bvalid stuck");
	a_rnext: assert property (p_rnext) else $error("no rvalid");
	a_rhold: assert property (p_rhold) else $error("rvalid lost");
	a_rdrop: assert property (p_rdrop) else $error("rvalid stuck");
	a_arblk: assert property (p_arblk) else $error("arready high");
endmodule
bind sector_protect_cmd_decoder sector_protect_cmd_decoder_checker chk_inst (
	.aclk(aclk), .aresetn(aresetn), .bus_read(bus_read),
	.bus_dout(bus_dout), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* File: dv/flash_host_model.sv */
// Purpose: host controller issuing flash bus cycles
// Assumes: strobes last one aclk cycle
// Notes:   released lines show the inverse of the last value
`default_nettype none
module flash_host_model (
	input  wire logic        aclk,
	output logic [23:0]      bus_addr,
	output logic [15:0]      bus_din,
	output logic             address_valid_strobe,
	output logic             write_strobe,
	output logic             chip_select_pulse,
	output logic             bus_clk_edge,
	output logic             bus_read,
	input  wire logic [15:0] bus_dout
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{bus_addr, bus_din} = '0;
		{address_valid_strobe, write_strobe} = 2'h0;
		{chip_select_pulse, bus_clk_edge, bus_read} = 3'h0;
	end
	// s picks which strobe opens the address and the data phase
	task automatic wr(input logic [23:0] a, input logic [15:0] d,
		input logic [1:0] s);
		bus_addr <= a;
		bus_din <= d;
		address_valid_strobe <= s[0];
		bus_clk_edge <= !s[0];
		write_strobe <= s[1];
		chip_select_pulse <= !s[1];
		@(posedge aclk);
		address_valid_strobe <= 1'b0;
		bus_clk_edge <= 1'b0;
		write_strobe <= 1'b0;
		chip_select_pulse <= 1'b0;
		bus_addr <= ~a;
		bus_din <= ~d;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [23:0] a, output logic [15:0] q);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge aclk);
		bus_read <= 1'b0;
		bus_addr <= ~a;
		@(posedge aclk);
		q = bus_dout;
	endtask
endmodule
`default_nettype wire

/* File: dv/sector_protect_cmd_decoder_bench.sv */
// Purpose: self-checking bench for the protection decoder
// Assumes: clk_en held high
// Notes:   host pins come from the host model
`include "sector_protect_cfg.svh"
`default_nettype none
module sector_protect_cmd_decoder_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, avs, we, cs, ce, rd;
	logic [23:0] ha;
	logic [15:0] hd, dout;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
	int          n_errors, compares;
	sector_protect_cmd_decoder sector_protect_cmd_decoder_inst (
		.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .bus_addr(ha),
		.bus_din(hd), .address_valid_strobe(avs), .write_strobe(we),
		.chip_select_pulse(cs), .bus_clk_edge(ce), .bus_read(rd),
		.bus_dout(dout), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rr));
	flash_host_model host (.aclk(aclk), .bus_addr(ha), .bus_din(hd),
		.address_valid_strobe(avs), .write_strobe(we),
		.chip_select_pulse(cs), .bus_clk_edge(ce), .bus_read(rd),
		.bus_dout(dout));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	function automatic logic [31:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// protected sectors read low on bit zero
	function automatic logic dq0(input logic locked);
		return !locked;
	endfunction
	task automatic test_done();
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic lim(input int i);
		if (i >= 40) begin
			n_errors++;
			test_done();
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		int i;
		awaddr <= a;
		wdata <= d;
		{awv, wv, br} <= 3'h7;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) break;
		end
		br <= 1'b0;
		lim(i);
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
		int i;
		araddr <= a;
		{arv, rr} <= 2'h3;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
			d = rdata;
			if (rv) break;
		end
		rr <= 1'b0;
		lim(i);
	endtask
	// command cycle with random upper address bits and upper data byte
	task automatic cw(input logic [13:0] a, input logic [7:0] d);
		logic [31:0] r;
		r = nxt();
		host.wr({r[31:22], a}, {r[15:8], d}, r[1:0]);
	endtask
	task automatic sw(input logic [8:0] s, input logic [7:0] d);
		logic [31:0] r;
		r = nxt();
		host.wr({1'b0, s, 14'h0000}, {r[15:8], d}, r[1:0]);
	endtask
	task automatic unlock(input logic [7:0] c);
		cw(`SP_ADDR_UNLOCK1, `SP_CMD_UNLOCK1);
		cw(`SP_ADDR_UNLOCK2, `SP_CMD_UNLOCK2);
		cw(`SP_ADDR_UNLOCK1, c);
	endtask
	task automatic leave();
		cw(seed[13:0], `SP_CMD_EXIT1);
		cw(seed[29:16], `SP_CMD_EXIT2);
	endtask
	initial begin
		logic [31:0] r, d, pa;
		logic [15:0] q;
		logic [15:0] pw [4];
		logic [8:0]  s;
		int          k, i, n;
		seed = 32'h00015FA4;
		{n_errors, compares} = '0;
		{aresetn, awv, wv, br, arv, rr} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(`SP_OFF_STATUS, d);
		chk(d, 32'h00000000);
		axi_wr(12'h020, nxt());
		axi_rd(12'h020, d);
		chk(d, 32'h00000000);
		unlock(`SP_CMD_VOL);
		cw(14'h0123, 8'h12);
		leave();
		leave();
		cw(14'h0123, `SP_CMD_WBUF);
		cw(14'h0000, `SP_CMD_RESET);
		for (k = 0; k < 3; k++) begin
			r = nxt();
			s = (k == 2) ? 9'h1FF : r[8:0];
			unlock(`SP_CMD_VOL);
			cw(r[29:16], `SP_CMD_PGM);
			sw(s, 8'h00);
			host.rd({1'b0, s, r[13:0]}, q);
			chk(q[0], dq0(1'b1));
			cw(r[27:14], `SP_CMD_PGM);
			sw(s, 8'h01);
			host.rd({1'b0, s, r[13:0]}, q);
			chk(q[0], dq0(1'b0));
			leave();
		end
		for (k = 1; k < 3; k++) begin
			r = nxt();
			n = (k == 2) ? 32 : r[1:0] + 1;
			pa = {8'h00, 1'b0, s, r[13:5], 5'h00};
			sw(s, `SP_CMD_WBUF);
			sw(s, 8'(n - 1));
			for (i = 0; i < n; i++) begin
				r = nxt();
				host.wr(pa[23:0] + 24'(i), r[15:0], r[17:16]);
			end
			sw(s, `SP_CMD_COMMIT);
			axi_rd(`SP_OFF_PROG, d);
			chk(d, 32'(k));
		end
		unlock(`SP_CMD_FREEZE);
		cw(r[13:0], `SP_CMD_PGM);
		cw(r[27:14], `SP_CMD_EXIT2);
		host.rd(r[23:0], q);
		chk(q[0], dq0(1'b1));
		axi_rd(`SP_OFF_STATUS, d);
		chk(d & 32'h0000000C, 32'h00000004);
		leave();
		// frozen: a volatile lock request must not take effect
		unlock(`SP_CMD_VOL);
		cw(r[13:0], `SP_CMD_PGM);
		sw(s, 8'h00);
		host.rd({1'b0, s, r[13:0]}, q);
		chk(q[0], dq0(1'b0));
		leave();
		host.rd({1'b0, s, r[13:0]}, q);
		chk(q, `SP_STAT_UNLOCK);
		// program four password words, read them back, then unlock
		r = nxt();
		unlock(`SP_CMD_PWD);
		for (i = 0; i < 4; i++) begin
			pw[i] = 16'(nxt());
			cw(r[13:0], `SP_CMD_PGM);
			host.wr({r[23:2], 2'(i)}, pw[i], r[1:0]);
		end
		for (i = 0; i < 4; i++) begin
			host.rd({r[23:2], 2'(i)}, q);
			chk(q, pw[i]);
		end
		cw(r[13:0], `SP_CMD_WBUF);
		cw(r[13:0], 8'h03);
		for (i = 0; i < 4; i++)
			host.wr({r[23:2], 2'(i)}, pw[i], r[3:2]);
		cw(r[13:0], `SP_CMD_COMMIT);
		leave();
		axi_rd(`SP_OFF_STATUS, d);
		chk(d & 32'h00000005, 32'h00000001);
		// persistent lock: set, read outside the set, erase all
		unlock(`SP_CMD_NVOL);
		cw(r[13:0], `SP_CMD_PGM);
		sw(s, 8'h00);
		host.rd({1'b0, s, r[13:0]}, q);
		chk(q[0], dq0(1'b1));
		leave();
		host.rd({1'b0, s, r[13:0]}, q);
		chk(q, `SP_STAT_LOCK);
		unlock(`SP_CMD_NVOL);
		cw(r[13:0], `SP_CMD_ERASE);
		sw(9'h000, `SP_CMD_ERASE2);
		leave();
		host.rd({1'b0, s, r[13:0]}, q);
		chk(q, `SP_STAT_UNLOCK);
		test_done();
	end
endmodule
`default_nettype wire
